// [mbsc_exec.sv]
// mbsc_exec: execute stage for and-literal, bit set, bit test/skip, calls
// assumes the register file is read combinationally into i_file_rdata
// and that fetch honours o_discard by replacing the next word with a nop
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - and literal into accumulator, zero flag only
// - set chosen file bit, flags untouched
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - skipped word becomes nop, two cycles
// - calls push program counter plus one
// - direct call: high buffer bits, literal
// - accumulator call: table pointer bits, accumulator
module mbsc_exec
    import mbsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire mbsc_pkg::mbsc_instr_t i_instr,
    input wire mbsc_pkg::mbsc_acc_wr_t i_acc_wr,
    input wire logic [7:0] i_file_rdata,
    input wire logic [7:0] i_pc_high_buffer,
    input wire logic [7:0] i_table_high_pointer,
    input wire logic [9:0] i_program_counter,
    output logic [7:0] o_accumulator,
    output logic o_zero_flag,
    output logic o_zero_we,
    output mbsc_pkg::mbsc_file_wr_t o_file_wr,
    output logic o_discard,
    output logic o_pc_load,
    output logic [9:0] o_program_counter,
    output logic o_busy,
    output logic [2:0] o_stack_ptr,
    output logic [9:0] o_stack_top
);
    import mbsc_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    mbsc_state_t state_q;
    mbsc_state_t state_d;
    logic go;
    logic is_and;
    logic is_bset;
    logic is_skc;
    logic is_sks;
    logic is_call;
    logic tested_bit;
    logic skip;
    logic [7:0] and_res;
    logic [7:0] bit_mask;
    logic [9:0] call_target;
    logic [9:0] ret_addr;

    function automatic logic [7:0] onehot8(input logic [2:0] sel);
        onehot8 = 8'h01 << sel;
    endfunction

    // a discarded word arrives during the bubble and must not execute
    assign go = i_ce && i_instr.valid && state_q == MBSC_ST_EXEC;
    assign is_and = go && i_instr.op == MBSC_OP_AND_LITERAL_INTO_ACC;
    assign is_bset = go && i_instr.op == MBSC_OP_FILE_BIT_SET;
    assign is_skc = go && i_instr.op == MBSC_OP_BIT_TEST_SKIP_CLEAR;
    assign is_sks = go && i_instr.op == MBSC_OP_BIT_TEST_SKIP_SET;
    assign is_call = go && i_instr.op == MBSC_OP_CALL;
    assign bit_mask = onehot8(i_instr.bit_sel);
    assign tested_bit = |(i_file_rdata & bit_mask);
    assign skip = (is_skc && !tested_bit) || (is_sks && tested_bit);
    assign and_res = o_accumulator & i_instr.literal;
    assign call_target = i_instr.call_via_accumulator
        ? {i_table_high_pointer[1:0], o_accumulator}
        : {i_pc_high_buffer[1:0], i_instr.literal};
    assign ret_addr = i_program_counter + MBSC_PC_ONE;

    // ------------------------------------------------------------
    // sequencing: skips and calls both spend one bubble cycle
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            MBSC_ST_EXEC:
                if (skip || is_call)
                    state_d = MBSC_ST_BUBBLE;
            MBSC_ST_BUBBLE:
                if (i_ce)
                    state_d = MBSC_ST_EXEC;
            default:
                state_d = MBSC_ST_EXEC;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            state_q <= MBSC_ST_EXEC;
        else if (i_ce)
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_accumulator <= MBSC_ACC_RST;
            o_zero_flag <= 1'b0;
            o_zero_we <= 1'b0;
        end
        else if (i_ce)
        begin
            o_zero_we <= is_and;
            if (is_and)
            begin
                o_accumulator <= and_res;
                o_zero_flag <= and_res == 8'h00;
            end
            // loads from other units; an and-literal in the same cycle wins
            else if (i_acc_wr.we)
                o_accumulator <= i_acc_wr.data;
        end
    end

    // ------------------------------------------------------------
    // file write, skip and program counter outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_file_wr <= '0;
            o_discard <= 1'b0;
            o_pc_load <= 1'b0;
            o_program_counter <= MBSC_PC_RST;
            o_busy <= 1'b0;
        end
        else if (i_ce)
        begin
            o_file_wr.we <= is_bset;
            o_file_wr.addr <= i_instr.file_addr;
            o_file_wr.data <= i_file_rdata | bit_mask;
            o_discard <= skip;
            o_pc_load <= is_call;
            o_busy <= state_d == MBSC_ST_BUBBLE;
            if (is_call)
                o_program_counter <= call_target;
        end
    end

    // ------------------------------------------------------------
    // return stack
    // ------------------------------------------------------------
    logic [2:0] sp_w;
    logic [9:0] top_w;

    mbsc_stack u_stack (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_push(is_call),
        .i_ret_addr(ret_addr),
        .o_sp(sp_w),
        .o_top(top_w)
    );

    // mirror pointer and top into flops so outputs stay registered;
    // the top only follows pushes, since empty slots carry no reset value
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_stack_ptr <= MBSC_SP_RST;
            o_stack_top <= MBSC_PC_RST;
        end
        else if (i_ce)
        begin
            o_stack_ptr <= is_call ? sp_w + MBSC_SP_ONE : sp_w;
            if (is_call)
                o_stack_top <= ret_addr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_skip_seen;
        i_ce && skip;
    endsequence

    sequence s_bubble;
        o_discard && state_q == MBSC_ST_BUBBLE;
    endsequence

    chk_and_result: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_and |=> o_accumulator == ($past(o_accumulator) & $past(i_instr.literal))
            && o_zero_we && o_zero_flag == (o_accumulator == 8'h00))
        else $error("and literal result or zero flag wrong");

    chk_bitset_write: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_bset |=> o_file_wr.we && !o_zero_we
            && o_file_wr.data[$past(i_instr.bit_sel)])
        else $error("bit set write missing");

    chk_skip_clear: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        i_ce && is_skc && !tested_bit |=> o_discard && !o_zero_we)
        else $error("skip on clear not taken");

    chk_skip_set: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        i_ce && is_sks |=> o_discard == $past(tested_bit))
        else $error("skip on set wrong");

    chk_skip_bubble: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        s_skip_seen |=> s_bubble)
        else $error("skip did not produce one bubble");

    chk_call_return: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_call |=> o_stack_top == $past(i_program_counter) + MBSC_PC_ONE)
        else $error("return address not pushed");

    chk_call_direct: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_call && !i_instr.call_via_accumulator |=> o_pc_load
            && o_program_counter == {$past(i_pc_high_buffer[1:0]),
                                     $past(i_instr.literal)} && o_busy)
        else $error("direct call target wrong");

    chk_call_acc: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_call && i_instr.call_via_accumulator |=> o_pc_load
            && o_program_counter[9:8] == $past(i_table_high_pointer[1:0])
            && o_program_counter[7:0] == $past(o_accumulator))
        else $error("accumulator call target wrong");

    chk_stack_slot: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        is_call |=> top_w == o_stack_top && sp_w == o_stack_ptr)
        else $error("pushed slot or stack pointer wrong");
endmodule
`default_nettype wire

// [mbsc_exec_tb.sv]
// mbsc_exec_tb: self-checking bench for the bit-op / skip / call unit
// assumes each taken word shows its effect one enabled cycle later
`timescale 1ns/1ps
`default_nettype none
module mbsc_exec_tb;
    import mbsc_pkg::*;
    // ----------------------------------------
    // stimulus, outputs and model state
    // ----------------------------------------
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b0;
    mbsc_instr_t i_instr = '0;
    mbsc_acc_wr_t i_acc_wr = '0;
    logic [7:0] i_file_rdata = 8'h00;
    logic [7:0] i_pc_high_buffer = 8'h00;
    logic [7:0] i_table_high_pointer = 8'h00;
    logic [9:0] i_program_counter = 10'h000;
    logic [7:0] o_accumulator;
    logic o_zero_flag, o_zero_we, o_discard, o_pc_load, o_busy;
    mbsc_file_wr_t o_file_wr;
    logic [9:0] o_program_counter, o_stack_top;
    logic [2:0] o_stack_ptr;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h53;
    logic [7:0] e_acc = 8'h00, e_fdata = 8'h00;
    logic [5:0] e_faddr = 6'h00;
    logic [9:0] e_pc = 10'h000, e_top = 10'h000;
    logic [2:0] e_sp = 3'h0;
    logic e_zwe = 1'b0, e_fwe = 1'b0, e_disc = 1'b0, e_pcl = 1'b0;
    logic e_busy = 1'b0, e_call = 1'b0;

    mbsc_exec dut_u (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_instr(i_instr),
        .i_acc_wr(i_acc_wr),
        .i_file_rdata(i_file_rdata), .i_pc_high_buffer(i_pc_high_buffer),
        .i_table_high_pointer(i_table_high_pointer),
        .i_program_counter(i_program_counter), .o_accumulator(o_accumulator),
        .o_zero_flag(o_zero_flag), .o_zero_we(o_zero_we),
        .o_file_wr(o_file_wr), .o_discard(o_discard), .o_pc_load(o_pc_load),
        .o_program_counter(o_program_counter), .o_busy(o_busy),
        .o_stack_ptr(o_stack_ptr), .o_stack_top(o_stack_top)
    );

    always #4 i_mclk = ~i_mclk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [9:0] call_target(input logic via_acc);
        if (via_acc)
            return {i_table_high_pointer[1:0], e_acc};
        return {i_pc_high_buffer[1:0], i_instr.literal};
    endfunction

    task automatic chk(input logic [9:0] seen, input logic [9:0] want);
        checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_outputs();
        chk(10'(o_accumulator), 10'(e_acc));
        chk(10'(o_zero_we), 10'(e_zwe));
        if (e_zwe)
            chk(10'(o_zero_flag), 10'(e_acc == 8'h00));
        chk(10'(o_file_wr.we), 10'(e_fwe));
        if (e_fwe)
        begin
            chk(10'(o_file_wr.addr), 10'(e_faddr));
            chk(10'(o_file_wr.data), 10'(e_fdata));
        end
        chk(10'(o_discard), 10'(e_disc));
        chk(10'(o_busy), 10'(e_busy));
        chk(10'(o_pc_load), 10'(e_pcl));
        chk(o_program_counter, e_pc);
        chk(o_stack_top, e_top);
        chk(10'(o_stack_ptr), 10'(e_sp));
    endtask

    // a frozen cycle (enable low) keeps every expectation as it was
    task automatic predict();
        logic hit;
        logic take;
        if (!i_ce)
            return;
        hit = i_file_rdata[i_instr.bit_sel];
        take = i_instr.valid && !e_busy;
        {e_zwe, e_fwe, e_disc, e_pcl, e_call} = 5'h00;
        if (take)
            case (i_instr.op)
                MBSC_OP_AND_LITERAL_INTO_ACC: e_zwe = 1'b1;
                MBSC_OP_FILE_BIT_SET: e_fwe = 1'b1;
                MBSC_OP_BIT_TEST_SKIP_CLEAR: e_disc = !hit;
                MBSC_OP_BIT_TEST_SKIP_SET: e_disc = hit;
                MBSC_OP_CALL: e_call = 1'b1;
                default: e_disc = 1'b0;
            endcase
        if (e_fwe)
        begin
            e_faddr = i_instr.file_addr;
            e_fdata = i_file_rdata | (8'h01 << i_instr.bit_sel);
        end
        e_pcl = e_call;
        e_pc = e_call ? call_target(i_instr.call_via_accumulator) : e_pc;
        e_top = e_call ? i_program_counter + MBSC_PC_ONE : e_top;
        e_sp = e_call ? e_sp + MBSC_SP_ONE : e_sp;
        e_busy = e_disc || e_call;
        // the call target above saw the old accumulator; and-literal wins
        if (e_zwe)
            e_acc = e_acc & i_instr.literal;
        else if (i_acc_wr.we)
            e_acc = i_acc_wr.data;
    endtask

    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // first words: every bit position, top file address, wrapping pc
    initial
    begin
        logic [31:0] r;
        logic [31:0] s;
        logic [31:0] t;
        repeat (20) @(negedge i_mclk);
        i_rst_n = 1'b1;
        for (int n = 0; n < 3000; n++)
        begin
            @(negedge i_mclk);
            check_outputs();
            seed = xs(seed);
            r = seed;
            seed = xs(seed);
            s = seed;
            i_ce = (n < 32) || (r[2:0] != 3'h0);
            i_instr.valid = (n < 32) || (r[4:3] != 2'h0);
            i_instr.call_via_accumulator = r[5];
            i_instr.literal = r[13:6];
            i_instr.file_addr = (n < 16) ? 6'h3F : r[19:14];
            i_instr.bit_sel = (n < 16) ? 3'(n) : r[22:20];
            i_file_rdata = r[30:23];
            i_program_counter = (n < 16) ? 10'h3FF : s[9:0];
            i_pc_high_buffer = s[17:10];
            i_table_high_pointer = s[25:18];
            seed = xs(seed);
            t = seed;
            i_acc_wr.we = t[0];
            i_acc_wr.data = t[8:1];
            i_instr.op = mbsc_op_t'(6'h01 << (s[31:26] % 6'h06));
            predict();
        end
        complete_run();
    end
endmodule
`default_nettype wire

// [mbsc_pkg.sv]
// mbsc_pkg: shared types and constants for the bit-op / skip / call unit
// assumes a core that presents one decoded instruction per cycle
package mbsc_pkg;
    localparam int MBSC_PC_W = 10;
    localparam int MBSC_SP_W = 3;
    localparam int MBSC_STACK_DEPTH = 8;
    localparam logic [9:0] MBSC_PC_RST = 10'h000;
    localparam logic [7:0] MBSC_ACC_RST = 8'h00;
    localparam logic [2:0] MBSC_SP_RST = 3'h0;
    localparam logic [9:0] MBSC_PC_ONE = 10'h001;
    localparam logic [2:0] MBSC_SP_ONE = 3'h1;

    typedef enum logic [5:0] {
        MBSC_OP_NONE = 6'h01,
        MBSC_OP_AND_LITERAL_INTO_ACC = 6'h02,
        MBSC_OP_FILE_BIT_SET = 6'h04,
        MBSC_OP_BIT_TEST_SKIP_CLEAR = 6'h08,
        MBSC_OP_BIT_TEST_SKIP_SET = 6'h10,
        MBSC_OP_CALL = 6'h20
    } mbsc_op_t;

    // no op code of its own for the accumulator call: MBSC_OP_CALL with call_via_accumulator set
    typedef struct packed {
        logic valid;
        mbsc_op_t op;
        logic call_via_accumulator;
        logic [7:0] literal;
        logic [5:0] file_addr;
        logic [2:0] bit_sel;
    } mbsc_instr_t;

    typedef struct packed {
        logic we;
        logic [5:0] addr;
        logic [7:0] data;
    } mbsc_file_wr_t;

    // accumulator loads issued by the core's other instructions
    typedef struct packed {
        logic we;
        logic [7:0] data;
    } mbsc_acc_wr_t;

    typedef enum logic [1:0] {
        MBSC_ST_EXEC = 2'h1,
        MBSC_ST_BUBBLE = 2'h2
    } mbsc_state_t;
endpackage

// [mbsc_stack.sv]
// mbsc_stack: hardware return stack, push only from this unit
// assumes pops are handled elsewhere in the core
`timescale 1ns/1ps
`default_nettype none
module mbsc_stack
    import mbsc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_push,
    input wire logic [9:0] i_ret_addr,
    output logic [2:0] o_sp,
    output logic [9:0] o_top
);
    logic [9:0] slot_q [MBSC_STACK_DEPTH];
    logic [2:0] sp_q;
    logic [2:0] sp_d;

    assign sp_d = i_push ? sp_q + MBSC_SP_ONE : sp_q;
    assign o_sp = sp_q;
    assign o_top = slot_q[sp_q - MBSC_SP_ONE];

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            sp_q <= MBSC_SP_RST;
        else if (i_ce)
            sp_q <= sp_d;
    end

    // slots carry no reset: contents are meaningless until pushed
    always_ff @(posedge i_mclk)
    begin
        if (i_ce && i_push)
            slot_q[sp_q] <= i_ret_addr;
    end

    chk_push_bumps_sp: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        i_ce && i_push |=> sp_q == $past(sp_q) + MBSC_SP_ONE)
        else $error("stack pointer not incremented on push");
endmodule
`default_nettype wire
